// *** rtl/chiop_host.sv ***
// host end: sequences one i/o read or write cycle on the pins
`timescale 1ns/1ps
module chiop_host (
  input wire logic clk,
  input wire logic rst_n,
  chiop_if.host bus,
  input wire chiop_pkg::chiop_mode_t mode,
  input wire logic req,
  input wire logic req_write,
  input wire logic [10:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic rd_buf_en
);
  chiop_pkg::chiop_hstate_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic [10:0] a_r, a_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic sel_r, sel_nxt;
  logic rs_r, rs_nxt;
  logic ws_r, ws_nxt;
  logic oe_r, oe_nxt;
  logic done_r, done_nxt;
  logic buf_r, buf_nxt;
  logic busy_r, busy_nxt;

  // cycle sequencer: setup, strobe, hold
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    a_nxt = a_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    sel_nxt = sel_r;
    rs_nxt = 1'b1;
    ws_nxt = 1'b1;
    oe_nxt = oe_r;
    done_nxt = 1'b0;
    // acknowledge enables input buffer; unused in ide mode
    buf_nxt = (mode == chiop_pkg::CHIOP_MODE_IO) &&
      !bus.input_acknowledge_n;
    case (st_r)
      chiop_pkg::CHIOP_H_IDLE: begin
        if (req) begin
          st_nxt = chiop_pkg::CHIOP_H_SETUP;
          cnt_nxt = chiop_pkg::SETUP_CYC;
          wr_nxt = req_write;
          // ide: upper address lines grounded
          a_nxt = (mode == chiop_pkg::CHIOP_MODE_IDE) ?
            {8'h00, req_addr[2:0]} : req_addr;
          wd_nxt = req_wdata;
          sel_nxt = 1'b1;
          oe_nxt = req_write; // host drives only on writes
        end
      end
      chiop_pkg::CHIOP_H_SETUP: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = chiop_pkg::CHIOP_H_STROBE;
          cnt_nxt = chiop_pkg::STROBE_CYC;
          rs_nxt = wr_r;
          ws_nxt = !wr_r;
        end
      end
      chiop_pkg::CHIOP_H_STROBE: begin
        cnt_nxt = cnt_r - 4'h1;
        rs_nxt = wr_r;
        ws_nxt = !wr_r;
        if (cnt_r == 4'h1) begin
          // release strobe; write is taken on this rising edge
          st_nxt = chiop_pkg::CHIOP_H_HOLD;
          rs_nxt = 1'b1;
          ws_nxt = 1'b1;
          if (!wr_r) begin
            rd_nxt = bus.host_data_lines;
          end
        end
      end
      chiop_pkg::CHIOP_H_HOLD: begin
        st_nxt = chiop_pkg::CHIOP_H_IDLE;
        sel_nxt = 1'b0;
        oe_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      default: begin
        st_nxt = chiop_pkg::CHIOP_H_IDLE;
      end
    endcase
    // registered busy is taken from st_nxt, so it matches st_r in the same cycle
    busy_nxt = (st_nxt != chiop_pkg::CHIOP_H_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= chiop_pkg::CHIOP_H_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      a_r <= 11'h000;
      wd_r <= chiop_pkg::DATA_RST;
      rd_r <= chiop_pkg::DATA_RST;
      sel_r <= 1'b0;
      rs_r <= 1'b1;
      ws_r <= 1'b1;
      oe_r <= 1'b0;
      done_r <= 1'b0;
      buf_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      a_r <= a_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      sel_r <= sel_nxt;
      rs_r <= rs_nxt;
      ws_r <= ws_nxt;
      oe_r <= oe_nxt;
      done_r <= done_nxt;
      buf_r <= buf_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign bus.addr = a_r;
  assign bus.card_sel_n = !sel_r;
  // register select low in i/o mode, tied high in ide
  assign bus.reg_sel_n = (mode == chiop_pkg::CHIOP_MODE_IDE);
  assign bus.io_read_strobe_n = rs_r;
  assign bus.io_write_strobe_n = ws_r;
  assign bus.host_data_out = wd_r;
  assign bus.host_data_oe = oe_r;
  assign busy = busy_r;
  assign done = done_r;
  assign rdata = rd_r;
  assign rd_buf_en = buf_r;
endmodule

// *** rtl/chiop_pkg.sv ***
// shared constants and types for the card host i/o strobe port
package chiop_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned TASK_SEL_W = 3;
  localparam int unsigned TASK_REGS = 8;
  localparam int unsigned IO_REGS = 16;
  localparam int unsigned IO_SEL_W = 4;
  // reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] IO_BASE_RST = 8'h00;
  // host strobe phase lengths in clk cycles (50 ns each)
  localparam int unsigned STROBE_NS = 150;
  localparam int unsigned CLK_NS = 50;
  localparam logic [3:0] STROBE_CYC =
    4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SETUP_CYC = 4'h1;

  typedef enum logic [1:0] {
    CHIOP_MODE_MEM,
    CHIOP_MODE_IO,
    CHIOP_MODE_IDE
  } chiop_mode_t;

  typedef enum {
    CHIOP_H_IDLE,
    CHIOP_H_SETUP,
    CHIOP_H_STROBE,
    CHIOP_H_HOLD
  } chiop_hstate_t;

  // byte lane helpers: even byte in d[7:0], odd byte in d[15:8]
  function automatic logic [7:0] even_byte(input logic [15:0] w);
    even_byte = w[7:0];
  endfunction

  function automatic logic [7:0] odd_byte(input logic [15:0] w);
    odd_byte = w[15:8];
  endfunction
endpackage

// *** rtl/chiop_if.sv ***
// pin-level link between host controller and card port
`timescale 1ns/1ps
interface chiop_if;
  logic [10:0] addr;
  logic card_sel_n;
  logic reg_sel_n;
  logic io_read_strobe_n;
  logic io_write_strobe_n;
  logic [15:0] host_data_out;
  logic host_data_oe;
  logic [15:0] card_data_out;
  logic card_data_oe;
  logic input_acknowledge_n;
  logic [15:0] host_data_lines;
  // bus level resolved from the two enables; floats high if nobody drives
  assign host_data_lines = card_data_oe ? card_data_out :
    host_data_oe ? host_data_out : 16'hffff;

  modport card (
    input addr, card_sel_n, reg_sel_n, io_read_strobe_n,
    input io_write_strobe_n, host_data_lines,
    output card_data_out, card_data_oe, input_acknowledge_n
  );
  modport host (
    output addr, card_sel_n, reg_sel_n, io_read_strobe_n,
    output io_write_strobe_n, host_data_out, host_data_oe,
    input host_data_lines, input_acknowledge_n
  );
endinterface

// *** rtl/chiop_card.sv ***
// card end: mode decode, strobe handling, register capture, read drive
`timescale 1ns/1ps
// Behaviour
// - ide mode: grounded select is master
// - d0 even byte lsb, d8 odd
// - ide task regs byte-wide, data 16-bit
// - acknowledge only on selected i/o read
// - host may gate buffers with acknowledge
// - drive read data while read strobe low
// - write strobe captures into addressed register
// - capture on write strobe rising edge
// - ide strobes behave as i/o mode
// - memory mode ignores strobes, no acknowledge
// - select input ignored outside ide mode
// - ide mode: acknowledge unused, left open
// - host holds register select low in i/o
// - ide uses three address lines only
module chiop_card (
  input wire logic clk,
  input wire logic rst_n,
  chiop_if.card bus,
  input wire chiop_pkg::chiop_mode_t mode,
  input wire logic master_slave_select_n,
  output logic is_master,
  output logic wr_pulse,
  output logic [3:0] wr_index,
  output logic [15:0] wr_data,
  output logic wr_data_word
);
  logic [15:0] io_regs_r [chiop_pkg::IO_REGS];
  logic [15:0] io_regs_nxt [chiop_pkg::IO_REGS];
  logic io_write_strobe_n_d_r, io_write_strobe_n_d_nxt;
  logic master_r, master_nxt;
  logic ack_r, ack_nxt;
  logic oe_r, oe_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic wp_r, wp_nxt;
  logic [3:0] wi_r, wi_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic ww_r, ww_nxt;
  logic strobes_on, rd_sel, wr_rise, data_port;
  logic [3:0] idx;

  // register index: ide uses a[2:0] only, word port at index 0
  function automatic logic [3:0] reg_index(
    input chiop_pkg::chiop_mode_t m, input logic [10:0] a);
    if (m == chiop_pkg::CHIOP_MODE_IDE) begin
      reg_index = {1'b0, a[2:0]};
    end else begin
      reg_index = a[3:0];
    end
  endfunction

  // decode of the current host cycle
  always_comb begin
    strobes_on = (mode != chiop_pkg::CHIOP_MODE_MEM);
    idx = reg_index(mode, bus.addr);
    data_port = (idx == 4'h0);
    // i/o mode requires register select low with the address
    rd_sel = strobes_on && !bus.card_sel_n && !bus.io_read_strobe_n &&
      (mode == chiop_pkg::CHIOP_MODE_IDE || !bus.reg_sel_n);
    // trailing edge: strobe was low last cycle, high now
    wr_rise = strobes_on && !io_write_strobe_n_d_r && bus.io_write_strobe_n &&
      !bus.card_sel_n;
  end

  // next state for capture, drive and acknowledge
  always_comb begin
    io_regs_nxt = io_regs_r;
    io_write_strobe_n_d_nxt = bus.io_write_strobe_n;
    wp_nxt = 1'b0;
    wi_nxt = wi_r;
    wd_nxt = wd_r;
    ww_nxt = ww_r;
    if (wr_rise) begin
      wp_nxt = 1'b1;
      wi_nxt = idx;
      if (mode == chiop_pkg::CHIOP_MODE_IDE && !data_port) begin
        // task registers take only the even byte lane
        io_regs_nxt[idx] = {8'h00,
          chiop_pkg::even_byte(bus.host_data_lines)};
        wd_nxt = {8'h00, chiop_pkg::even_byte(bus.host_data_lines)};
        ww_nxt = 1'b0;
      end else begin
        io_regs_nxt[idx] = bus.host_data_lines;
        wd_nxt = bus.host_data_lines;
        ww_nxt = 1'b1;
      end
    end
    // drive only during a selected read strobe
    oe_nxt = rd_sel;
    dout_nxt = io_regs_r[idx];
    if (mode == chiop_pkg::CHIOP_MODE_IDE && !data_port) begin
      dout_nxt = {8'h00, chiop_pkg::even_byte(io_regs_r[idx])};
    end
    // acknowledge in i/o card mode only
    ack_nxt = !(rd_sel && mode == chiop_pkg::CHIOP_MODE_IO);
    // select strap only matters in ide mode
    master_nxt = (mode == chiop_pkg::CHIOP_MODE_IDE) &&
      !master_slave_select_n;
  end

  // registers; strap sampled by the clock, not by the reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < chiop_pkg::IO_REGS; i++) begin
        io_regs_r[i] <= chiop_pkg::DATA_RST;
      end
      io_write_strobe_n_d_r <= 1'b1;
      master_r <= 1'b0;
      ack_r <= 1'b1;
      oe_r <= 1'b0;
      dout_r <= chiop_pkg::DATA_RST;
      wp_r <= 1'b0;
      wi_r <= 4'h0;
      wd_r <= chiop_pkg::DATA_RST;
      ww_r <= 1'b0;
    end else begin
      io_regs_r <= io_regs_nxt;
      io_write_strobe_n_d_r <= io_write_strobe_n_d_nxt;
      master_r <= master_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
      dout_r <= dout_nxt;
      wp_r <= wp_nxt;
      wi_r <= wi_nxt;
      wd_r <= wd_nxt;
      ww_r <= ww_nxt;
    end
  end

  assign bus.card_data_out = dout_r;
  assign bus.card_data_oe = oe_r;
  assign bus.input_acknowledge_n = ack_r;
  assign is_master = master_r;
  assign wr_pulse = wp_r;
  assign wr_index = wi_r;
  assign wr_data = wd_r;
  assign wr_data_word = ww_r;
endmodule

// *** bench/chiop_asserts.sv ***
// pin-level assertions on the host to card link
`timescale 1ns/1ps
module chiop_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire chiop_pkg::chiop_mode_t mode,
  input wire logic card_sel_n,
  input wire logic reg_sel_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic host_data_oe,
  input wire logic card_data_oe,
  input wire logic input_acknowledge_n
);
  logic rd_io;
  logic rd_any;
  // selected read as the card must decode it
  assign rd_io = !card_sel_n && !io_read_strobe_n && !reg_sel_n &&
    mode == chiop_pkg::CHIOP_MODE_IO;
  // ide ignores register select, so only the strobe and select count
  assign rd_any = rd_io || (!card_sel_n && !io_read_strobe_n &&
    mode == chiop_pkg::CHIOP_MODE_IDE);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_read_drives: assert property (
    rd_any |=> card_data_oe) else $error("read not driven");
  a_ack_on_io: assert property (
    rd_io |=> !input_acknowledge_n) else $error("ack missing");
  a_ack_cause: assert property (
    !input_acknowledge_n |-> $past(rd_io)) else $error("stray ack");
  a_ack_unused: assert property (
    mode != chiop_pkg::CHIOP_MODE_IO |-> input_acknowledge_n)
    else $error("ack outside i/o mode");
  a_drive_cause: assert property (
    card_data_oe |-> $past(rd_any)) else $error("stray drive");
  a_mem_quiet: assert property (
    mode == chiop_pkg::CHIOP_MODE_MEM |=> !card_data_oe)
    else $error("drive in memory mode");
  a_read_release: assert property (
    $rose(io_read_strobe_n) |=> !card_data_oe)
    else $error("bus held after read");
  a_no_fight: assert property (
    !(card_data_oe && host_data_oe)) else $error("bus contention");
  a_io_regsel: assert property (
    mode == chiop_pkg::CHIOP_MODE_IO && !card_sel_n |-> !reg_sel_n)
    else $error("register select high in i/o");
  a_write_data: assert property (
    !io_write_strobe_n |-> host_data_oe) else $error("write undriven");
endmodule

// *** bench/tb_card_host_io_strobe_port.sv ***
// bench: host and card ends joined, driven from the host user side
`timescale 1ns/1ps
module tb_card_host_io_strobe_port;
  logic clk, rst_n, ms_n, req, req_write;
  chiop_pkg::chiop_mode_t mode;
  logic [10:0] req_addr;
  logic [15:0] req_wdata, wr_data, rdata, g_data;
  logic [3:0] wr_index, g_idx;
  logic is_master, wr_pulse, wr_data_word, busy, done, rd_buf_en;
  logic g_word, g_buf, g_busy;
  int miscompares, checks_done, pulses;
  chiop_if i_chiop_if();
  chiop_card i_chiop_card (.clk(clk), .rst_n(rst_n), .bus(i_chiop_if),
    .mode(mode), .master_slave_select_n(ms_n), .is_master(is_master),
    .wr_pulse(wr_pulse), .wr_index(wr_index), .wr_data(wr_data),
    .wr_data_word(wr_data_word));
  chiop_host i_chiop_host (.clk(clk), .rst_n(rst_n), .bus(i_chiop_if),
    .mode(mode), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata),
    .rd_buf_en(rd_buf_en));
  chiop_asserts i_chiop_asserts (.clk(clk), .rst_n(rst_n), .mode(mode),
    .card_sel_n(i_chiop_if.card_sel_n), .reg_sel_n(i_chiop_if.reg_sel_n),
    .io_read_strobe_n(i_chiop_if.io_read_strobe_n),
    .io_write_strobe_n(i_chiop_if.io_write_strobe_n),
    .host_data_oe(i_chiop_if.host_data_oe),
    .card_data_oe(i_chiop_if.card_data_oe),
    .input_acknowledge_n(i_chiop_if.input_acknowledge_n));
  // 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one host cycle; card captures and buffer enable are logged meanwhile
  task automatic op(input logic w, input logic [10:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    pulses = 0;
    g_buf = 1'b0;
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1) g_busy = busy;
      if (rd_buf_en === 1'b1) g_buf = 1'b1;
      if (wr_pulse === 1'b1) begin
        pulses++;
        g_idx = wr_index;
        g_data = wr_data;
        g_word = wr_data_word;
      end
    end
    if (n >= 20) miscompares++;
    // slack so the next request lands in idle
    repeat (2) @(posedge clk);
  endtask
  task automatic wr_chk(input logic [10:0] a, input logic [15:0] d,
    input logic [15:0] dexp, input logic word);
    op(1'b1, a, d);
    check("pulses", 16'(pulses), 16'h0001);
    check("wr_index", {12'h000, g_idx}, {12'h000, a[3:0]});
    check("wr_word", {15'h0000, g_word}, {15'h0000, word});
    check("wr_data", g_data, dexp);
    check("busy", {14'h0000, g_busy, busy}, 16'h0002);
  endtask
  task automatic rd_chk(input logic [10:0] a, input logic [15:0] exp,
    input logic b);
    op(1'b0, a, 16'h0000);
    check("rdata", rdata, exp);
    check("rd_buf_en", {15'h0000, g_buf}, {15'h0000, b});
  endtask
  task automatic t_io();
    mode <= chiop_pkg::CHIOP_MODE_IO;
    @(posedge clk);
    wr_chk(11'h005, 16'h3c81, 16'h3c81, 1'b1);
    wr_chk(11'h00a, 16'h7e02, 16'h7e02, 1'b1);
    rd_chk(11'h005, 16'h3c81, 1'b1);
    rd_chk(11'h00a, 16'h7e02, 1'b1);
    $display("test io done");
  endtask
  task automatic t_ide();
    mode <= chiop_pkg::CHIOP_MODE_IDE;
    ms_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("master", {15'h0000, is_master}, 16'h0001);
    wr_chk(11'h000, 16'hbeef, 16'hbeef, 1'b1);
    wr_chk(11'h003, 16'h12a5, 16'h00a5, 1'b0);
    rd_chk(11'h003, 16'h00a5, 1'b0);
    ms_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("slave", {15'h0000, is_master}, 16'h0000);
    $display("test ide done");
  endtask
  // strobes must be ignored; a later i/o read proves nothing was written
  task automatic t_mem();
    mode <= chiop_pkg::CHIOP_MODE_MEM;
    ms_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("mem master", {15'h0000, is_master}, 16'h0000);
    op(1'b1, 11'h005, 16'h5555);
    check("mem pulses", 16'(pulses), 16'h0000);
    rd_chk(11'h005, 16'hffff, 1'b0);
    mode <= chiop_pkg::CHIOP_MODE_IO;
    repeat (3) @(posedge clk);
    check("io master", {15'h0000, is_master}, 16'h0000);
    rd_chk(11'h005, 16'h3c81, 1'b1);
    $display("test mem done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    ms_n = 1'b1;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 11'h000;
    req_wdata = 16'h0000;
    mode = chiop_pkg::CHIOP_MODE_IO;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_io();
    t_ide();
    t_mem();
    stop_test();
  end
  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
